/* File: verilog/ddr_burst2_pkg.sv */
// Purpose: shared constants for the burst-of-two DDR SRAM port and its controller
// Assumes: one 36-bit wide data path; narrow mode uses the low 8 bits
// Notes: the modelled array is shallow; only the low row bits of the address are kept
//
// Operation
// RQ1 - low load strobe marks address and direction
// RQ2 - every access moves exactly two words
// RQ3 - direction high reads, low writes
// RQ4 - accesses start only on link clock rise
// RQ5 - nibble selects sampled with each data beat
// RQ6 - nibble select 0 gates 3:0, 1 gates 7:4
// RQ7 - byte selects sampled with each data beat
// RQ8 - each byte select gates one 9-bit lane
// RQ9 - deselected lanes never reach the array
// RQ10 - one address bus serves reads and writes
// RQ11 - narrow mode forces burst start to zero
// RQ12 - wide mode loads burst counter from lowest bit
// RQ13 - address ignored unless a load is presented
// RQ14 - read data launched on output clock pair
// RQ15 - control and address taken on rising edge
// RQ16 - second write beat taken on falling edge
// RQ17 - single clock mode launches on link clock
// RQ18 - data outputs released when no read active
// RQ19 - controller presents beat 0 rise, beat 1 fall
package ddr_burst2_pkg;
    // ==========================================
    // widths
    localparam int DATA_W = 36;
    localparam int ADDR_W = 20;
    localparam int SEL_W = 4;
    localparam int NIB_W = 2;
    localparam int LANE_W = 9;
    localparam int NIB_LANE_W = 4;
    localparam int NARROW_W = 8;
    localparam int BURST_LEN = 2;
    // ==========================================
    // modelled array
    localparam int ROW_W = 6;
    localparam int MEM_DEPTH = 1 << ROW_W;
    // ==========================================
    // controller sequencing, steps counted in clk cycles after issue
    localparam logic [2:0] ST_LD_END = 3'h0;
    localparam logic [2:0] ST_DATA0 = 3'h1;
    localparam logic [2:0] ST_DATA1 = 3'h2;
    localparam logic [2:0] ST_WR_END = 3'h3;
    localparam logic [2:0] ST_RD0 = 3'h4;
    localparam logic [2:0] ST_RD1 = 3'h5;
    localparam logic [3:0] INIT_CYCLES = 4'h8;
    // ==========================================
    // reset values
    localparam logic [SEL_W-1:0] SEL_IDLE = 4'hf;
    localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
endpackage

/* File: verilog/ddr_burst2_if.sv */
// Purpose: pins between the SRAM port and its memory controller
// Assumes: the controller makes both clocks; the falling edge stands for the complement
// Notes: the shared data pins are resolved here from the two enables
`timescale 1ns/1ps
interface ddr_burst2_if;
    import ddr_burst2_pkg::*;
    // ==========================================
    // clocks
    logic kClk; // link input clock
    logic cClk; // output data clock
    // ==========================================
    // command and address
    logic loadStrobeN; // low marks a new burst
    logic rwSel; // high read, low write
    logic [ADDR_W-1:0] addrHi; // shared address bus
    logic lowestBurstBit; // burst start or row lsb
    // ==========================================
    // write selects
    logic [SEL_W-1:0] byteWriteSelN; // wide lanes
    logic [NIB_W-1:0] nibbleWriteSelN; // narrow lanes
    // ==========================================
    // shared data pins
    logic [DATA_W-1:0] hostDq;
    logic hostDqOe;
    logic [DATA_W-1:0] devDq;
    logic devDqOe;
    logic [DATA_W-1:0] dq; // resolved level
    // device wins; an undriven bus reads zero
    assign dq = devDqOe ? devDq : (hostDqOe ? hostDq : DATA_ZERO);
    modport device (
        input kClk, cClk, loadStrobeN, rwSel, addrHi, lowestBurstBit,
        input byteWriteSelN, nibbleWriteSelN, dq,
        output devDq, devDqOe
    );
    modport host (
        output kClk, cClk, loadStrobeN, rwSel, addrHi, lowestBurstBit,
        output byteWriteSelN, nibbleWriteSelN, hostDq, hostDqOe,
        input dq
    );
endinterface

/* File: verilog/ddr_burst2_device.sv */
// Purpose: SRAM side of the burst-of-two DDR port: decode, masked write, read launch
// Assumes: controller keeps the link timing; straps are static while running
// Notes: no reset pin; pipeline flags flush after two link cycles with load high
`timescale 1ns/1ps
module ddr_burst2_device
    import ddr_burst2_pkg::*;
(
    // link to the controller
    ddr_burst2_if.device link,
    // configuration straps
    input wire logic narrowCfg,
    input wire logic singleClockMode
);
    // ==========================================
    // clocks
    // ==========================================
    wire kClk;
    wire outClk;
    assign kClk = link.kClk;
    // read data rides the output clock pair, or the link clock alone
    assign outClk = singleClockMode ? kClk : link.cClk; // RQ14 RQ17

    // ==========================================
    // strap capture
    // ==========================================
    logic narrowMeta_reg; // first stage, read only by the next flop
    logic narrowCfg_reg; // settled narrow mode

    // two flops before any logic reads the strap
    always_ff @(posedge kClk) begin
        narrowMeta_reg <= narrowCfg;
        narrowCfg_reg <= narrowMeta_reg;
    end

    // ==========================================
    // command decode
    // ==========================================
    wire loadSeen; // a burst is being defined this edge
    wire readCmd; // load with direction high
    wire writeCmd; // load with direction low
    wire [ROW_W-1:0] cmdRow; // pair row of the loaded address
    wire cmdStart; // first word index of the burst
    wire [ROW_W-1:0] narrowRow; // narrow row, lowest pin is the row lsb

    assign loadSeen = ~link.loadStrobeN; // RQ1
    assign readCmd = loadSeen & link.rwSel; // RQ3
    assign writeCmd = loadSeen & ~link.rwSel; // RQ3
    // one bus carries both directions' addresses
    assign narrowRow = {link.addrHi[ROW_W-2:0], link.lowestBurstBit}; // RQ10
    assign cmdRow = narrowCfg_reg ? narrowRow : link.addrHi[ROW_W-1:0];
    // narrow bursts always begin at word zero of the pair
    assign cmdStart = narrowCfg_reg ? 1'b0 : link.lowestBurstBit; // RQ11 RQ12

    // ==========================================
    // write lane masks from the select pins
    // ==========================================
    wire [DATA_W-1:0] pinMask; // high where the lane is written
    wire [DATA_W-1:0] widthMask; // bits that exist in the current mode

    // one mask bit per data bit, taken from its lane select
    for (genvar i = 0; i < DATA_W; i++) begin : g_mask
        if (i < NARROW_W) begin : g_low
            // low bits follow nibble selects in narrow mode
            assign pinMask[i] = narrowCfg_reg ?
                ~link.nibbleWriteSelN[i / NIB_LANE_W] :
                ~link.byteWriteSelN[i / LANE_W]; // RQ6 RQ8
            assign widthMask[i] = 1'b1;
        end else begin : g_high
            // upper bits exist only in wide mode
            assign pinMask[i] = ~narrowCfg_reg & ~link.byteWriteSelN[i / LANE_W]; // RQ8
            assign widthMask[i] = ~narrowCfg_reg;
        end
    end

    // ==========================================
    // write pipeline
    // ==========================================
    logic wrPend_reg; // write loaded, first beat due next rise
    logic [ROW_W-1:0] wrRow_reg; // row held from the load edge
    logic wrStart_reg; // burst start held from the load edge
    logic commitPend_reg; // both beats held, commit on next rise
    logic [ROW_W-1:0] cRow_reg; // row to commit
    logic cStart_reg; // start word to commit
    logic [DATA_W-1:0] beat0Data_reg; // first beat, rising edge
    logic [DATA_W-1:0] beat0Mask_reg; // its lane mask
    logic [DATA_W-1:0] beat1Data_reg; // second beat, falling edge
    logic [DATA_W-1:0] beat1Mask_reg; // its lane mask

    // load edge and first beat; address is kept only on a load
    always_ff @(posedge kClk) begin
        wrPend_reg <= writeCmd; // RQ4 RQ15
        commitPend_reg <= wrPend_reg;
        if (writeCmd) begin
            // address taken only while a load is presented
            wrRow_reg <= cmdRow; // RQ13
            wrStart_reg <= cmdStart;
        end
        if (wrPend_reg) begin
            // first beat and its selects on the same rising edge
            cRow_reg <= wrRow_reg;
            cStart_reg <= wrStart_reg;
            beat0Data_reg <= link.dq; // RQ5 RQ7
            beat0Mask_reg <= pinMask & widthMask;
        end
    end

    // second beat and its selects on the falling edge
    always_ff @(negedge kClk) begin
        beat1Data_reg <= link.dq; // RQ16 RQ5 RQ7
        beat1Mask_reg <= pinMask & widthMask;
    end

    // ==========================================
    // array
    // ==========================================
    logic [DATA_W-1:0] memSlot0 [0:MEM_DEPTH-1]; // word 0 of each pair
    logic [DATA_W-1:0] memSlot1 [0:MEM_DEPTH-1]; // word 1 of each pair
    wire [DATA_W-1:0] slot0Data; // beat landing on word 0
    wire [DATA_W-1:0] slot0Mask;
    wire [DATA_W-1:0] slot1Data; // beat landing on word 1
    wire [DATA_W-1:0] slot1Mask;
    wire [DATA_W-1:0] slot0New; // merged word 0
    wire [DATA_W-1:0] slot1New; // merged word 1

    // the counter walks linearly from the start word, wrapping in the pair
    assign slot0Data = cStart_reg ? beat1Data_reg : beat0Data_reg; // RQ12
    assign slot0Mask = cStart_reg ? beat1Mask_reg : beat0Mask_reg;
    assign slot1Data = cStart_reg ? beat0Data_reg : beat1Data_reg;
    assign slot1Mask = cStart_reg ? beat0Mask_reg : beat1Mask_reg;
    // deselected lanes keep old contents; their data is dropped
    assign slot0New = (memSlot0[cRow_reg] & ~slot0Mask) | (slot0Data & slot0Mask); // RQ9
    assign slot1New = (memSlot1[cRow_reg] & ~slot1Mask) | (slot1Data & slot1Mask); // RQ9

    // both words of the burst are committed together
    always_ff @(posedge kClk) begin
        if (commitPend_reg) begin
            memSlot0[cRow_reg] <= slot0New; // RQ2
            memSlot1[cRow_reg] <= slot1New; // RQ2
        end
    end

    // ==========================================
    // read pipeline
    // ==========================================
    logic rdPend_reg; // read loaded on the last rise
    logic [DATA_W-1:0] rdWord0_reg; // first word out
    logic [DATA_W-1:0] rdWord1_reg; // second word out

    // fetch the pair in burst order at the load edge
    always_ff @(posedge kClk) begin
        rdPend_reg <= readCmd; // RQ4
        if (readCmd) begin
            // a commit on this same edge is not yet visible
            if (cmdStart) begin
                rdWord0_reg <= memSlot1[cmdRow] & widthMask; // RQ12
                rdWord1_reg <= memSlot0[cmdRow] & widthMask;
            end else begin
                rdWord0_reg <= memSlot0[cmdRow] & widthMask; // RQ11
                rdWord1_reg <= memSlot1[cmdRow] & widthMask;
            end
        end
    end

    // ==========================================
    // output launch
    // ==========================================
    logic oe_reg; // drive enable for one output clock period
    logic [DATA_W-1:0] qPos_reg; // word launched on the rise
    logic [DATA_W-1:0] qNeg_reg; // word launched on the fall

    // first word on the output clock rise; release when idle
    always_ff @(posedge outClk) begin
        oe_reg <= rdPend_reg; // RQ18
        if (rdPend_reg) begin
            qPos_reg <= rdWord0_reg; // RQ14 RQ17
        end
    end

    // second word on the output clock fall of the same period
    always_ff @(negedge outClk) begin
        if (oe_reg) begin
            qNeg_reg <= rdWord1_reg; // RQ14 RQ17 RQ2
        end
    end

    // high phase shows the first word, low phase the second
    assign link.devDq = outClk ? qPos_reg : qNeg_reg;
    // pins released whenever no read is being returned
    assign link.devDqOe = oe_reg; // RQ18
endmodule

/* File: verilog/ddr_burst2_host.sv */
// Purpose: memory controller end: divides clk into the link clocks and runs bursts
// Assumes: one request in flight; link pins change on clk rise, link edges on clk fall
// Notes: read words pass two flops before capture
`timescale 1ns/1ps
module ddr_burst2_host
    import ddr_burst2_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link to the SRAM
    ddr_burst2_if.host link,
    // request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [ADDR_W:0] reqAddr,
    input wire logic [DATA_W-1:0] reqData0,
    input wire logic [DATA_W-1:0] reqData1,
    input wire logic [SEL_W-1:0] reqSel0N,
    input wire logic [SEL_W-1:0] reqSel1N,
    // answer
    output logic rspValid,
    output logic [DATA_W-1:0] rspData0,
    output logic [DATA_W-1:0] rspData1
);
    typedef enum logic [1:0] {
        HS_INIT = 2'b00,
        HS_IDLE = 2'b01,
        HS_BUSY = 2'b10
    } host_state_e;

    // ==========================================
    // state
    // ==========================================
    host_state_e state_reg; // sequencer state
    logic [2:0] step_reg; // cycles since issue
    logic [3:0] initCnt_reg; // startup flush count
    logic kClk_reg; // divided link clock
    logic isWrite_reg; // burst direction
    logic ldN_reg;
    logic rw_reg;
    logic [ADDR_W:0] addr_reg;
    logic [SEL_W-1:0] sel_reg;
    logic [DATA_W-1:0] dq_reg;
    logic dqOe_reg;
    logic [DATA_W-1:0] d1Hold_reg; // second beat held
    logic [SEL_W-1:0] s1Hold_reg;
    logic [DATA_W-1:0] d0Hold_reg; // first beat held
    logic [SEL_W-1:0] s0Hold_reg;
    logic [DATA_W-1:0] dqMeta_reg; // first sampling stage
    logic [DATA_W-1:0] dqSync_reg; // second sampling stage
    logic rspValid_reg;
    logic [DATA_W-1:0] rsp0_reg;
    logic [DATA_W-1:0] rsp1_reg;

    // ==========================================
    // decode
    // ==========================================
    wire busy;
    wire issue;
    wire atLdEnd;
    wire atData0;
    wire atData1;
    wire atWrEnd;
    wire atRd0;
    wire atRd1;
    // issue only where the next clk fall makes a link rise
    assign reqReady = (state_reg == HS_IDLE) & ~kClk_reg;
    assign issue = reqValid & reqReady;
    assign busy = state_reg == HS_BUSY;
    assign atLdEnd = busy & (step_reg == ST_LD_END);
    assign atData0 = busy & isWrite_reg & (step_reg == ST_DATA0);
    assign atData1 = busy & isWrite_reg & (step_reg == ST_DATA1);
    assign atWrEnd = busy & isWrite_reg & (step_reg == ST_WR_END);
    assign atRd0 = busy & ~isWrite_reg & (step_reg == ST_RD0);
    assign atRd1 = busy & ~isWrite_reg & (step_reg == ST_RD1);

    // ==========================================
    // link clock divider, toggles on clk fall
    // ==========================================
    always_ff @(negedge clk) begin
        if (reset) begin
            kClk_reg <= 1'b0;
        end else begin
            kClk_reg <= ~kClk_reg;
        end
    end

    // read data sampling, two flops before use
    always_ff @(posedge clk) begin
        dqMeta_reg <= link.dq;
        dqSync_reg <= dqMeta_reg;
    end

    // ==========================================
    // sequencer
    // ==========================================
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= HS_INIT;
            initCnt_reg <= 4'h0;
            step_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                HS_INIT: begin
                    // hold load high so the SRAM pipeline flushes
                    initCnt_reg <= initCnt_reg + 4'h1;
                    if (initCnt_reg == INIT_CYCLES - 4'h1) begin
                        state_reg <= HS_IDLE;
                    end
                end
                HS_IDLE: begin
                    step_reg <= 3'h0;
                    if (issue) begin
                        state_reg <= HS_BUSY;
                    end
                end
                HS_BUSY: begin
                    step_reg <= step_reg + 3'h1;
                    if (atWrEnd | atRd1) begin
                        state_reg <= HS_IDLE;
                    end
                end
                default: begin
                    state_reg <= HS_INIT;
                end
            endcase
        end
    end

    // command pins: one load per burst, held for one link rise
    always_ff @(posedge clk) begin
        if (reset) begin
            ldN_reg <= 1'b1;
            rw_reg <= 1'b1;
            addr_reg <= '0;
            isWrite_reg <= 1'b0;
        end else if (issue) begin
            ldN_reg <= 1'b0; // RQ1
            rw_reg <= ~reqWrite; // RQ3
            addr_reg <= reqAddr; // RQ10
            isWrite_reg <= reqWrite;
        end else if (atLdEnd) begin
            ldN_reg <= 1'b1;
        end
    end

    // request data held for the beats
    always_ff @(posedge clk) begin
        if (issue) begin
            d0Hold_reg <= reqData0;
            s0Hold_reg <= reqSel0N;
            d1Hold_reg <= reqData1;
            s1Hold_reg <= reqSel1N;
        end
    end

    // write beats: first before a link rise, second before the fall
    always_ff @(posedge clk) begin
        if (reset) begin
            dqOe_reg <= 1'b0;
            sel_reg <= SEL_IDLE;
            dq_reg <= DATA_ZERO;
        end else if (atData0) begin
            dqOe_reg <= 1'b1;
            dq_reg <= d0Hold_reg; // RQ19
            sel_reg <= s0Hold_reg;
        end else if (atData1) begin
            dq_reg <= d1Hold_reg; // RQ19
            sel_reg <= s1Hold_reg;
        end else if (atWrEnd) begin
            dqOe_reg <= 1'b0;
            sel_reg <= SEL_IDLE;
        end
    end

    // answers: write done pulse, or two read words then pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            rspValid_reg <= 1'b0;
            rsp0_reg <= DATA_ZERO;
            rsp1_reg <= DATA_ZERO;
        end else begin
            rspValid_reg <= atWrEnd | atRd1;
            if (atRd0) begin
                rsp0_reg <= dqSync_reg; // RQ2
            end
            if (atRd1) begin
                rsp1_reg <= dqSync_reg; // RQ2
            end
        end
    end

    // ==========================================
    // outputs
    // ==========================================
    assign link.kClk = kClk_reg;
    assign link.cClk = kClk_reg;
    assign link.loadStrobeN = ldN_reg;
    assign link.rwSel = rw_reg;
    assign link.addrHi = addr_reg[ADDR_W:1];
    assign link.lowestBurstBit = addr_reg[0];
    assign link.byteWriteSelN = sel_reg;
    assign link.nibbleWriteSelN = sel_reg[NIB_W-1:0];
    assign link.hostDq = dq_reg;
    assign link.hostDqOe = dqOe_reg;
    assign rspValid = rspValid_reg;
    assign rspData0 = rsp0_reg;
    assign rspData1 = rsp1_reg;
endmodule

/* File: verif/ddr_burst2_checker.sv */
// Purpose: link protocol checks between the SRAM port and its controller
// Assumes: sampled on the controller clock; link edges fall between its rising edges
// Notes: the port has no reset, so every check waits on the controller reset
`timescale 1ns/1ps
module ddr_burst2_checker
    import ddr_burst2_pkg::*;
(
    // controller clock and reset
    input wire logic clk,
    input wire logic reset,
    // link signals
    input wire logic kClk,
    input wire logic cClk,
    input wire logic loadStrobeN,
    input wire logic rwSel,
    input wire logic [SEL_W-1:0] byteWriteSelN,
    input wire logic [NIB_W-1:0] nibbleWriteSelN,
    input wire logic hostDqOe,
    input wire logic devDqOe
);
    // ==========================================
    // clocking and decoded commands
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire wrLoad = !loadStrobeN && !rwSel; // write command on the bus
    wire rdLoad = !loadStrobeN && rwSel; // read command on the bus
    // ==========================================
    // command strobe
    a_load_single: assert property ($fell(loadStrobeN) |=> loadStrobeN)
        else $error("load strobe held low");
    a_load_on_rise: assert property (!loadStrobeN |-> kClk)
        else $error("load strobe misses a link rise");
    a_load_spacing: assert property ($rose(loadStrobeN) |-> loadStrobeN [*5])
        else $error("bursts too close");
    // ==========================================
    // data beats
    a_write_beats: assert property (wrLoad |-> ##2 hostDqOe [*2] ##1 !hostDqOe)
        else $error("write beats wrong");
    a_read_launch: assert property (rdLoad |-> ##2 devDqOe [*2] ##1 !devDqOe)
        else $error("read words wrong");
    a_write_quiet: assert property (wrLoad |-> !devDqOe [*5])
        else $error("port drives during write");
    a_read_quiet: assert property (rdLoad |-> !hostDqOe [*5])
        else $error("controller drives during read");
    a_release_idle: assert property ($rose(devDqOe) |-> $past(rdLoad, 2))
        else $error("port drives without read");
    // ==========================================
    // selects and clocks
    a_sel_idle: assert property (!hostDqOe |-> byteWriteSelN == SEL_IDLE)
        else $error("selects active outside beats");
    a_nibble_tie: assert property (nibbleWriteSelN == byteWriteSelN[NIB_W-1:0])
        else $error("nibble selects differ");
    a_clock_pair: assert property ((cClk == kClk) and (kClk |=> !kClk))
        else $error("output clock off");
    // main scenarios
    cover property (wrLoad);
    cover property (rdLoad);
    cover property (hostDqOe && byteWriteSelN != SEL_IDLE && byteWriteSelN != 4'h0);
endmodule

/* File: verif/testbench.sv */
// Purpose: drives the controller request port against the SRAM port
// Assumes: one request in flight; straps change only while idle
// Notes: a shadow of the array gives every expected read word
`timescale 1ns/1ps
module testbench
    import ddr_burst2_pkg::*;
;
    // ==========================================
    // request rows and signals
    typedef struct {
        logic w; // write when high
        logic n; // narrow strap
        logic c; // single clock strap
        logic [ADDR_W:0] a;
        logic [DATA_W-1:0] d0;
        logic [DATA_W-1:0] d1;
        logic [SEL_W-1:0] s0;
        logic [SEL_W-1:0] s1;
    } row_s;
    localparam int NROWS = 15;
    row_s rows [NROWS] = '{
        '{1'b1, 1'b0, 1'b0, 21'h2, 36'h123456789, 36'habcdef012, 4'h0, 4'h0},
        '{1'b0, 1'b0, 1'b0, 21'h2, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b0, 1'b0, 1'b0, 21'h3, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b1, 1'b0, 1'b0, 21'h3, 36'h0f0f0f0f0, 36'h5a5a5a5a5, 4'ha, 4'h5},
        '{1'b0, 1'b0, 1'b0, 21'h2, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b1, 1'b0, 1'b0, 21'h4, 36'h111111111, 36'h222222222, 4'h0, 4'h0},
        '{1'b1, 1'b0, 1'b0, 21'h4, 36'hfffffffff, 36'hfffffffff, 4'hf, 4'hf},
        '{1'b0, 1'b0, 1'b0, 21'h5, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b1, 1'b0, 1'b0, 21'h5, 36'h333333333, 36'h444444444, 4'he, 4'h7},
        '{1'b0, 1'b0, 1'b1, 21'h4, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b0, 1'b0, 1'b1, 21'h3, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b1, 1'b1, 1'b0, 21'h31, 36'hfedcba987, 36'h76543210f, 4'h0, 4'h0},
        '{1'b0, 1'b1, 1'b0, 21'h31, 36'h0, 36'h0, 4'hf, 4'hf},
        '{1'b1, 1'b1, 1'b1, 21'h31, 36'h0000000aa, 36'h0000000bb, 4'he, 4'hd},
        '{1'b0, 1'b1, 1'b1, 21'h31, 36'h0, 36'h0, 4'hf, 4'hf}
    };
    row_s cur = '{1'b0, 1'b0, 1'b0, 21'h0, 36'h0, 36'h0, 4'hf, 4'hf}; // request in hand
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reqValid = 1'b0;
    logic reqReady;
    logic rspValid;
    logic [DATA_W-1:0] rspData0;
    logic [DATA_W-1:0] rspData1;
    logic [DATA_W-1:0] shadow [int]; // expected words, key is pair times two plus word
    int bad_count = 0;
    int n_compared = 0;
    // clock of 4 ns
    always #2 clk = ~clk;
    // ==========================================
    // both ends and the checker
    ddr_burst2_if link ();
    ddr_burst2_device u_ddr_burst2_device (.link(link.device), .narrowCfg(cur.n),
        .singleClockMode(cur.c));
    ddr_burst2_host u_ddr_burst2_host (.clk(clk), .reset(reset), .link(link.host),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(cur.w), .reqAddr(cur.a),
        .reqData0(cur.d0), .reqData1(cur.d1), .reqSel0N(cur.s0), .reqSel1N(cur.s1),
        .rspValid(rspValid), .rspData0(rspData0), .rspData1(rspData1));
    ddr_burst2_checker u_ddr_burst2_checker (.clk(clk), .reset(reset), .kClk(link.kClk),
        .cClk(link.cClk), .loadStrobeN(link.loadStrobeN), .rwSel(link.rwSel),
        .byteWriteSelN(link.byteWriteSelN), .nibbleWriteSelN(link.nibbleWriteSelN),
        .hostDqOe(link.hostDqOe), .devDqOe(link.devDqOe));
    // ==========================================
    // compare and close
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // lane merge: unselected lanes keep the old word, narrow words keep 8 bits
    function automatic logic [DATA_W-1:0] merge(input int k, input logic [DATA_W-1:0] nw,
            input logic [SEL_W-1:0] selN);
        logic [DATA_W-1:0] r;
        r = shadow.exists(k) ? shadow[k] : {DATA_W{1'bx}};
        for (int i = 0; i < SEL_W; i++) begin
            if (cur.n && i < NIB_W && !selN[i]) begin
                r[i*NIB_LANE_W +: NIB_LANE_W] = nw[i*NIB_LANE_W +: NIB_LANE_W];
            end else if (!cur.n && !selN[i]) begin
                r[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
            end
        end
        if (cur.n) begin
            r[DATA_W-1:NARROW_W] = 28'h0; // narrow port stores 8 bits only
        end
        return r;
    endfunction
    // one burst through the controller, then update or compare the shadow
    task automatic run(input row_s r);
        int n;
        int k;
        int w0;
        @(negedge clk);
        if (cur.n !== r.n) begin
            cur.n = r.n;
            repeat (8) @(negedge clk);
        end
        cur = r;
        k = r.n ? (32'h400000 + int'(r.a)) * 2 : int'(r.a[ADDR_W:1]) * 2;
        w0 = r.n ? 0 : int'(r.a[0]);
        reqValid = 1'b1;
        n = 0;
        #1;
        while (reqReady !== 1'b1 && n < 40) begin
            @(negedge clk);
            #1;
            n++;
        end
        @(negedge clk);
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(36'(rspValid), 36'h1);
        if (r.w) begin
            shadow[k+w0] = merge(k + w0, r.d0, r.s0);
            shadow[k+1-w0] = merge(k + 1 - w0, r.d1, r.s1);
        end else begin
            check(rspData0, shadow[k+w0]);
            check(rspData1, shadow[k+1-w0]);
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        check(36'({reqReady, rspValid, link.hostDqOe, link.loadStrobeN}), 36'h1);
        // non-blocking: the link clock divider samples reset on this same falling edge
        reset <= 1'b0;
        for (int i = 0; i < NROWS; i++) begin
            run(rows[i]);
        end
        // second reset mid-run; the array keeps its contents
        @(negedge clk);
        reset <= 1'b1;
        repeat (8) @(negedge clk);
        check(36'({reqReady, rspValid, link.hostDqOe, link.loadStrobeN}), 36'h1);
        reset <= 1'b0;
        run(rows[12]);
        run(rows[4]);
        print_verdict();
    end
    // watchdog against a hang
    initial begin
        #20000;
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
